// *** itw_pkg.sv ***
// itw_pkg: constants, register map, field layout and carrier structs
// for the interval timer and watchdog block.
// assumes: one 250 MHz clock, registers reached over an Avalon-MM slave.
package itw_pkg;

  // clock rate of the system clock, in MHz
  localparam int unsigned CLK_MHZ = 250;

  // register indices and their byte addresses (index times four)
  localparam logic [7:0] IDX_INTERVAL_TIMER_CONTROL = 8'h8B;
  localparam logic [7:0] IDX_INTERVAL_TIMER_COUNT   = 8'h8C;
  localparam logic [7:0] IDX_WATCHDOG_CONTROL       = 8'h8D;
  localparam logic [7:0] IDX_WATCHDOG_COUNT         = 8'h8E;
  localparam logic [9:0] ADDR_INTERVAL_TIMER_CONTROL = {IDX_INTERVAL_TIMER_CONTROL, 2'b00};
  localparam logic [9:0] ADDR_INTERVAL_TIMER_COUNT   = {IDX_INTERVAL_TIMER_COUNT, 2'b00};
  localparam logic [9:0] ADDR_WATCHDOG_CONTROL       = {IDX_WATCHDOG_CONTROL, 2'b00};
  localparam logic [9:0] ADDR_WATCHDOG_COUNT         = {IDX_WATCHDOG_COUNT, 2'b00};

  // interval_control field positions
  localparam int unsigned IC_FLAG_BIT   = 7;
  localparam int unsigned IC_CKSEL_LSB  = 5;
  localparam int unsigned IC_CLEAR_BIT  = 3;
  localparam int unsigned IC_OVFSEL_LSB = 0;

  // watchdog_control_reg field positions
  localparam int unsigned WC_EN_BIT    = 7;
  localparam int unsigned WC_RSMODE_BIT = 6;
  localparam int unsigned WC_CLEAR_BIT = 5;
  localparam int unsigned WC_CKSEL_BIT = 1;
  localparam int unsigned WC_FLAG_BIT  = 0;

  // reset values
  localparam logic [2:0] RST_OVFSEL = 3'h1;
  localparam logic [1:0] RST_CKSEL  = 2'h0;
  localparam logic [7:0] RST_PERIOD = 8'hFF;

  // prescaler width covers the largest divisor, 4096
  localparam int unsigned PRE_W = 12;
  localparam logic [PRE_W-1:0] DIV4096_MASK = 12'hFFF;
  localparam logic [PRE_W-1:0] DIV1024_MASK = 12'h3FF;
  localparam logic [PRE_W-1:0] DIV128_MASK  = 12'h07F;
  localparam logic [PRE_W-1:0] DIV16_MASK   = 12'h00F;

  // interval clock select encodings
  typedef enum logic [1:0] {
    CK_DIV4096 = 2'h0,
    CK_DIV1024 = 2'h1,
    CK_DIV128  = 2'h2,
    CK_DIV16   = 2'h3
  } itw_cksel_e;

  // avalon-mm request from the master
  typedef struct packed {
    logic        read;
    logic        write;
    logic [9:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } itw_avs_req_s;

  // state of the main module
  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic [7:0]       icnt;
    logic [1:0]       icksel;
    logic [2:0]       iovfsel;
    logic             iclr;
    logic             iflag;
    logic             stable;
    logic [7:0]       wcnt;
    logic [7:0]       wper;
    logic             wen;
    logic             wrsmode;
    logic             wclr;
    logic             wcksel;
    logic             wflag;
    logic             wrst;
    logic             wait_n;
    logic [31:0]      rdata;
  } itw_state_s;

  localparam itw_state_s ITW_RST = '{
    pre:     '0,
    icnt:    8'h00,
    icksel:  RST_CKSEL,
    iovfsel: RST_OVFSEL,
    iclr:    1'b0,
    iflag:   1'b0,
    stable:  1'b0,
    wcnt:    8'h00,
    wper:    RST_PERIOD,
    wen:     1'b0,
    wrsmode: 1'b0,
    wclr:    1'b0,
    wcksel:  1'b0,
    wflag:   1'b0,
    wrst:    1'b0,
    wait_n:  1'b0,
    rdata:   32'h0000_0000
  };

  // state of the oscillator tick synchroniser
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic tick;
  } itw_sync_s;

  localparam itw_sync_s ITW_SYNC_RST = '{s1: 1'b0, s2: 1'b0, s3: 1'b0, tick: 1'b0};

endpackage : itw_pkg

// *** itw_rc_tick.sv ***
// itw_rc_tick: brings the watchdog rc oscillator into the system clock
// domain and turns each rising edge into a one-cycle tick.
// assumes: the oscillator is much slower than i_clk (kHz against MHz).
`timescale 1ns/10ps
module itw_rc_tick (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  // oscillator level and gate
  input  wire logic i_rc_level,
  input  wire logic i_enable,
  // tick out
  output logic      o_tick
);

  itw_pkg::itw_sync_s st_r;
  itw_pkg::itw_sync_s st_nxt;

  // two flops before any logic; edge found between second and third
  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.s1   = i_rc_level;
    st_nxt.s2   = st_r.s1;
    st_nxt.s3   = st_r.s2;
    st_nxt.tick = i_enable & st_r.s2 & ~st_r.s3;
  end

  // state register
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      st_r <= itw_pkg::ITW_SYNC_RST;
    else
      st_r <= st_nxt;
  end

  assign o_tick = st_r.tick; // straight from a flop

endmodule : itw_rc_tick

// *** itw_timer.sv ***
// itw_timer: 8-bit free-running interval timer with prescaler and overflow
// tick, plus an 8-bit watchdog counter with period compare, interrupt flag
// and cpu reset request, all behind an Avalon-MM slave.
// assumes: acknowledge and stop-exit strobes come from logic on i_clk;
// the rc oscillator level is asynchronous and is synchronised here.
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/10ps

// Operation
// RULE_01: interval counter is 8 bits, counts freely, nothing stops it.
// RULE_02: writing one to interval clear zeroes counter; clear bit self-clears next cycle.
// RULE_03: interval clock select picks clock divided by 4096, 1024, 128 or 16.
// RULE_04: overflow select k overflows at counter bit k, period 2^(k+1); default one.
// RULE_05: interval flag sets on overflow; cleared by writing zero or acknowledge.
// RULE_06: interval timer gives stabilisation wait after power-on and after stop exit.
// RULE_07: watchdog counter advances on each interval overflow tick.
// RULE_08: watchdog clock select zero uses overflow tick; one enables and uses rc oscillator.
// RULE_09: watchdog has 8-bit counter and period; flag raised when they match.
// RULE_10: watchdog interval is overflow interval times period plus one.
// RULE_11: reset-mode bit 6 zero gives interrupts; one makes match reset the cpu.
// RULE_12: writing one to watchdog clear zeroes counter; clear bit self-clears next cycle. The code zeroes the counter only while watchdog enable is set.
// RULE_13: watchdog flag sets on event; cleared by writing zero or acknowledge.
// RULE_14: counter read and period write share one address; never load period zero.
// RULE_15: watchdog enable gates counting, flag setting and reset generation.
// RULE_16: after each match the watchdog counter returns to zero and keeps counting.
module itw_timer (
  // clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_arst_n,
  // avalon-mm slave
  input  wire itw_pkg::itw_avs_req_s i_avs,
  output logic [31:0]               o_avs_readdata,
  output logic                      o_avs_waitrequest,
  // cpu side strobes
  input  wire logic                 i_interval_irq_ack,
  input  wire logic                 i_watchdog_irq_ack,
  input  wire logic                 i_stop_exit,
  // watchdog rc oscillator
  input  wire logic                 i_wdt_rc_level,
  output logic                      o_wdt_rc_enable,
  // events out
  output logic                      o_interval_irq,
  output logic                      o_watchdog_irq,
  output logic                      o_cpu_reset,
  output logic                      o_osc_stable
);

  itw_pkg::itw_state_s st_r;
  itw_pkg::itw_state_s st_nxt;

  logic                      rc_tick;
  logic [itw_pkg::PRE_W-1:0] pre_mask;
  logic                      pre_tick;
  logic [7:0]                ovf_mask;
  logic                      ovf_tick;
  logic                      wdt_tick;
  logic                      wdt_match;
  logic                      acc;
  logic                      acc_wr;
  logic                      acc_rd;
  logic [7:0]                wbyte;
  logic [7:0]                rbyte;
  logic                      hit_ic;
  logic                      hit_icnt;
  logic                      hit_wc;
  logic                      hit_wcnt;

  // rc oscillator runs only while selected, so its tick is gated here too
  itw_rc_tick u_rc_tick (
    .i_clk      (i_clk),
    .i_arst_n   (i_arst_n),
    .i_rc_level (i_wdt_rc_level),
    .i_enable   (st_r.wcksel),
    .o_tick     (rc_tick)
  );

  // prescaler divisor choice; a tick when the low bits are all ones
  always_comb
  begin
    case (itw_pkg::itw_cksel_e'(st_r.icksel))
      itw_pkg::CK_DIV4096: pre_mask = itw_pkg::DIV4096_MASK; // [RULE_03]
      itw_pkg::CK_DIV1024: pre_mask = itw_pkg::DIV1024_MASK; // [RULE_03]
      itw_pkg::CK_DIV128:  pre_mask = itw_pkg::DIV128_MASK;  // [RULE_03]
      default:             pre_mask = itw_pkg::DIV16_MASK;   // [RULE_03]
    endcase
  end

  assign pre_tick = ((st_r.pre & pre_mask) == pre_mask);

  // overflow at counter bit k: low k+1 bits all ones on an interval clock
  assign ovf_mask = 8'((9'h002 << st_r.iovfsel) - 9'h001);              // [RULE_04]
  assign ovf_tick = pre_tick && ((st_r.icnt & ovf_mask) == ovf_mask);   // [RULE_04]

  // watchdog clock source and compare
  assign wdt_tick  = st_r.wcksel ? rc_tick : ovf_tick;                  // [RULE_07] [RULE_08]
  assign wdt_match = st_r.wen && !st_r.wclr && wdt_tick
                     && (st_r.wcnt == st_r.wper);                       // [RULE_09] [RULE_10]

  // bus decode; an access completes on the cycle waitrequest is low
  assign acc    = (i_avs.read || i_avs.write) && st_r.wait_n;
  assign acc_wr = acc && i_avs.write && i_avs.byteenable[0];
  assign acc_rd = i_avs.read;
  assign wbyte  = i_avs.writedata[7:0];

  always_comb
  begin
    hit_ic   = 1'b0;
    hit_icnt = 1'b0;
    hit_wc   = 1'b0;
    hit_wcnt = 1'b0;
    if (i_avs.address == itw_pkg::ADDR_INTERVAL_TIMER_CONTROL)
      hit_ic = 1'b1;
    else if (i_avs.address == itw_pkg::ADDR_INTERVAL_TIMER_COUNT)
      hit_icnt = 1'b1;
    else if (i_avs.address == itw_pkg::ADDR_WATCHDOG_CONTROL)
      hit_wc = 1'b1;
    else if (i_avs.address == itw_pkg::ADDR_WATCHDOG_COUNT)
      hit_wcnt = 1'b1;
  end

  // read mux; unmapped addresses read as zero
  always_comb
  begin
    rbyte = 8'h00;
    if (hit_ic)
    begin
      rbyte[itw_pkg::IC_FLAG_BIT]                      = st_r.iflag;
      rbyte[itw_pkg::IC_CKSEL_LSB +: 2]                = st_r.icksel;
      rbyte[itw_pkg::IC_CLEAR_BIT]                     = st_r.iclr;
      rbyte[itw_pkg::IC_OVFSEL_LSB +: 3]               = st_r.iovfsel;
    end
    else if (hit_icnt)
      rbyte = st_r.icnt;
    else if (hit_wc)
    begin
      rbyte[itw_pkg::WC_EN_BIT]     = st_r.wen;
      rbyte[itw_pkg::WC_RSMODE_BIT] = st_r.wrsmode;
      rbyte[itw_pkg::WC_CLEAR_BIT]  = st_r.wclr;
      rbyte[itw_pkg::WC_CKSEL_BIT]  = st_r.wcksel;
      rbyte[itw_pkg::WC_FLAG_BIT]   = st_r.wflag;
    end
    else if (hit_wcnt)
      rbyte = st_r.wcnt; // the period register is write-only [RULE_14]
  end

  // next-state logic
  always_comb
  begin
    st_nxt = st_r;

    // one wait state per access: waitrequest low one cycle after the request
    st_nxt.wait_n = (i_avs.read || i_avs.write) && !st_r.wait_n;
    if (acc_rd && !st_r.wait_n)
      st_nxt.rdata = {24'h000000, rbyte};

    // prescaler and interval counter never stop
    st_nxt.pre = st_r.pre + 1'b1;                               // [RULE_01]
    if (pre_tick)
      st_nxt.icnt = st_r.icnt + 8'h01;                          // [RULE_01]

    // clear strobes live one cycle; the clear itself wins over counting
    st_nxt.iclr = 1'b0;                                         // [RULE_02]
    st_nxt.wclr = 1'b0;                                         // [RULE_12]
    if (st_r.iclr)
    begin
      st_nxt.icnt = 8'h00;                                      // [RULE_02]
      st_nxt.pre  = '0;
    end

    // stop exit restarts the count and drops the stable indication
    if (i_stop_exit)
    begin
      st_nxt.icnt   = 8'h00;                                    // [RULE_06]
      st_nxt.pre    = '0;
      st_nxt.stable = 1'b0;                                     // [RULE_06]
    end
    else if (ovf_tick)
      st_nxt.stable = 1'b1;                                     // [RULE_06]

    // interval flag: ack or write of zero clears, a new overflow wins
    if (i_interval_irq_ack)
      st_nxt.iflag = 1'b0;                                      // [RULE_05]

    // watchdog counter, gated by enable; reset-mode pulse lasts one cycle
    st_nxt.wrst = 1'b0;
    if (st_r.wen)                                               // [RULE_15]
    begin
      if (st_r.wclr)
        st_nxt.wcnt = 8'h00;                                    // [RULE_12]
      else if (wdt_match)
        st_nxt.wcnt = 8'h00;                                    // [RULE_16]
      else if (wdt_tick)
        st_nxt.wcnt = st_r.wcnt + 8'h01;                        // [RULE_07]
    end
    if (wdt_match && st_r.wrsmode)
      st_nxt.wrst = 1'b1;                                       // [RULE_11]

    if (i_watchdog_irq_ack)
      st_nxt.wflag = 1'b0;                                      // [RULE_13]

    // register writes
    if (acc_wr)
    begin
      if (hit_ic)
      begin
        if (!wbyte[itw_pkg::IC_FLAG_BIT])
          st_nxt.iflag = 1'b0;                                  // [RULE_05]
        st_nxt.icksel  = wbyte[itw_pkg::IC_CKSEL_LSB +: 2];     // [RULE_03]
        st_nxt.iovfsel = wbyte[itw_pkg::IC_OVFSEL_LSB +: 3];    // [RULE_04]
        st_nxt.iclr    = wbyte[itw_pkg::IC_CLEAR_BIT];          // [RULE_02]
      end
      else if (hit_wc)
      begin
        if (!wbyte[itw_pkg::WC_FLAG_BIT])
          st_nxt.wflag = 1'b0;                                  // [RULE_13]
        st_nxt.wen     = wbyte[itw_pkg::WC_EN_BIT];             // [RULE_15]
        st_nxt.wrsmode = wbyte[itw_pkg::WC_RSMODE_BIT];         // [RULE_11]
        st_nxt.wclr    = wbyte[itw_pkg::WC_CLEAR_BIT];          // [RULE_12]
        st_nxt.wcksel  = wbyte[itw_pkg::WC_CKSEL_BIT];          // [RULE_08]
      end
      else if (hit_wcnt)
        st_nxt.wper = wbyte;                                    // [RULE_14]
    end

    // sets last so an event in the clearing cycle is not lost
    if (ovf_tick)
      st_nxt.iflag = 1'b1;                                      // [RULE_05]
    if (wdt_match)
      st_nxt.wflag = 1'b1;                                      // [RULE_09] [RULE_13]
  end

  // state register
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      st_r <= itw_pkg::ITW_RST;
    else
      st_r <= st_nxt;
  end

  // outputs straight from flops
  assign o_avs_readdata    = st_r.rdata;
  assign o_avs_waitrequest = ~st_r.wait_n;
  assign o_interval_irq    = st_r.iflag;
  assign o_watchdog_irq    = st_r.wflag;   // flag stands in either mode [RULE_11]
  assign o_cpu_reset       = st_r.wrst;
  assign o_osc_stable      = st_r.stable;
  assign o_wdt_rc_enable   = st_r.wcksel;  // [RULE_08]

endmodule : itw_timer

// *** itw_props.sv ***
// itw_props: port-level timing checks for the interval timer and watchdog.
// assumes: bound to itw_timer, one clock domain, async active-low reset.
`timescale 1ns/10ps
module itw_props (
  // clock and reset
  input wire logic                  i_clk,
  input wire logic                  i_arst_n,
  // register bus
  input wire itw_pkg::itw_avs_req_s i_avs,
  input wire logic [31:0]           o_avs_readdata,
  input wire logic                  o_avs_waitrequest,
  // strobes and events
  input wire logic                  i_interval_irq_ack,
  input wire logic                  i_watchdog_irq_ack,
  input wire logic                  i_stop_exit,
  input wire logic                  i_wdt_rc_level,
  input wire logic                  o_wdt_rc_enable,
  input wire logic                  o_interval_irq,
  input wire logic                  o_watchdog_irq,
  input wire logic                  o_cpu_reset,
  input wire logic                  o_osc_stable
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  logic [7:0] wc_r;
  logic       wc_wr;
  logic       mapped;
  // completed lane-0 write to the watchdog control register
  assign wc_wr = i_avs.write && !o_avs_waitrequest && i_avs.byteenable[0]
                 && i_avs.address == itw_pkg::ADDR_WATCHDOG_CONTROL;
  assign mapped = i_avs.address inside {itw_pkg::ADDR_INTERVAL_TIMER_CONTROL, itw_pkg::ADDR_INTERVAL_TIMER_COUNT,
                                        itw_pkg::ADDR_WATCHDOG_CONTROL, itw_pkg::ADDR_WATCHDOG_COUNT};
  // shadow of enable and mode, so gating can be judged without the body
  always_ff @(posedge i_clk or negedge i_arst_n)
    if (!i_arst_n)
      wc_r <= 8'h00;
    else if (wc_wr)
      wc_r <= i_avs.writedata[7:0];
  sequence s_req;
    (i_avs.read || i_avs.write) && o_avs_waitrequest;
  endsequence
  sequence s_done;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence
  bus_one_wait_a: assert property (s_req |=> s_done) else $error("bus access not one wait cycle");
  unmapped_zero_a: assert property (i_avs.read && o_avs_waitrequest && !mapped |=> o_avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  rdata_upper_a: assert property (i_avs.read && !o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  iack_clear_a: assert property (i_interval_irq_ack |-> ##[1:2] !o_interval_irq)
    else $error("interval flag not cleared by ack");
  wack_clear_a: assert property (i_watchdog_irq_ack |-> ##[1:2] !o_watchdog_irq)
    else $error("watchdog flag not cleared by ack");
  rst_pulse_a: assert property (o_cpu_reset |=> !o_cpu_reset) else $error("reset pulse too long");
  // the pulse is launched from the control bits one cycle older than the shadow at this edge
  rst_gate_a: assert property (o_cpu_reset |-> $past(wc_r[7] && wc_r[6]))
    else $error("reset outside enabled reset mode");
  rst_flag_a: assert property (o_cpu_reset |-> ##[0:2] o_watchdog_irq)
    else $error("reset without watchdog flag");
  wirq_gate_a: assert property ($rose(o_watchdog_irq) |-> $past(wc_r[7]))
    else $error("watchdog flag while disabled");
  stop_wait_a: assert property (i_stop_exit |-> ##[1:2] !o_osc_stable)
    else $error("no wait after stop exit");
  rc_follow_a: assert property ($changed(o_wdt_rc_enable) |-> $past(wc_wr) || $past(wc_wr, 2))
    else $error("rc enable moved without a write");
endmodule : itw_props
bind itw_timer itw_props u_props (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_avs(i_avs),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .i_interval_irq_ack(i_interval_irq_ack),
  .i_watchdog_irq_ack(i_watchdog_irq_ack), .i_stop_exit(i_stop_exit), .i_wdt_rc_level(i_wdt_rc_level),
  .o_wdt_rc_enable(o_wdt_rc_enable), .o_interval_irq(o_interval_irq), .o_watchdog_irq(o_watchdog_irq),
  .o_cpu_reset(o_cpu_reset), .o_osc_stable(o_osc_stable));

// *** itw_cpu_model.sv ***
// itw_cpu_model: cpu acknowledge logic and the watchdog rc oscillator.
// assumes: same clock as the timer; acks only while the bench allows it.
`timescale 1ns/10ps
module itw_cpu_model (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  // bench control
  input  wire logic i_ack_en,
  // timer side
  input  wire logic i_interval_irq,
  input  wire logic i_watchdog_irq,
  input  wire logic i_rc_enable,
  output logic      o_interval_ack,
  output logic      o_watchdog_ack,
  output logic      o_rc_level
);
  logic [3:0] iq_r;
  logic [3:0] wq_r;
  logic [4:0] rc_cnt_r;
  // one ack per request, three cycles late like an interrupt entry
  assign o_interval_ack = iq_r[2] && !iq_r[3];
  assign o_watchdog_ack = wq_r[2] && !wq_r[3];
  // oscillator halts low while disabled, period 40 clocks when running
  always_ff @(posedge i_clk or negedge i_arst_n)
    if (!i_arst_n)
    begin
      iq_r       <= 4'h0;
      wq_r       <= 4'h0;
      rc_cnt_r   <= 5'h00;
      o_rc_level <= 1'b0;
    end
    else
    begin
      iq_r     <= {iq_r[2:0], i_interval_irq && i_ack_en};
      wq_r     <= {wq_r[2:0], i_watchdog_irq && i_ack_en};
      rc_cnt_r <= (!i_rc_enable || rc_cnt_r == 5'h13) ? 5'h00 : rc_cnt_r + 5'h01;
      if (!i_rc_enable)
        o_rc_level <= 1'b0;
      else if (rc_cnt_r == 5'h13)
        o_rc_level <= !o_rc_level;
    end
endmodule : itw_cpu_model

// *** itw_timer_test.sv ***
// itw_timer_test: register-level tests of the interval timer and watchdog.
// assumes: itw_props bound to the design, cpu model on the far side.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin failures++; $display("Error %s expected %h seen %h", nm, ex, got); end end
module itw_timer_test;
  localparam logic [9:0] A_IC = itw_pkg::ADDR_INTERVAL_TIMER_CONTROL;
  localparam logic [9:0] A_IN = itw_pkg::ADDR_INTERVAL_TIMER_COUNT;
  localparam logic [9:0] A_WC = itw_pkg::ADDR_WATCHDOG_CONTROL;
  localparam logic [9:0] A_WN = itw_pkg::ADDR_WATCHDOG_COUNT;
  logic i_clk, i_arst_n, stop, ack_en, rc_lvl, rc_en, iack, wack, iirq, wirq, cpu_rst, stable, wreq;
  logic [31:0] rdata, x;
  logic [7:0] v1, v2;
  itw_pkg::itw_avs_req_s avs;
  int failures, tests_run, cyc, n, t1;
  int dv[4] = '{4096, 1024, 128, 16};
  itw_timer dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_avs(avs), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_interval_irq_ack(iack), .i_watchdog_irq_ack(wack), .i_stop_exit(stop),
    .i_wdt_rc_level(rc_lvl), .o_wdt_rc_enable(rc_en), .o_interval_irq(iirq), .o_watchdog_irq(wirq),
    .o_cpu_reset(cpu_rst), .o_osc_stable(stable));
  itw_cpu_model u_cpu (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_ack_en(ack_en), .i_interval_irq(iirq),
    .i_watchdog_irq(wirq), .i_rc_enable(rc_en), .o_interval_ack(iack), .o_watchdog_ack(wack), .o_rc_level(rc_lvl));
  // 250 MHz clock and a free cycle count
  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = !i_clk;
  end
  always @(posedge i_clk) cyc <= cyc + 1;
  // one bus access: hold until waitrequest is sampled low
  task automatic acc(input logic wr, input logic [9:0] a, input logic [7:0] d, input logic [3:0] be);
    int k;
    k = 0;
    @(posedge i_clk);
    avs <= '{read: !wr, write: wr, address: a, writedata: {24'h0, d}, byteenable: be};
    do
    begin
      @(posedge i_clk);
      k++;
    end
    while (wreq !== 1'b0 && k < 100);
    x = rdata;
    if (k >= 100) failures++;
    avs <= '{default: '0};
  endtask : acc
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    acc(1'b1, a, d, 4'hF);
  endtask : wr
  task automatic rdc(input logic [9:0] a, input logic [7:0] e, input string nm);
    acc(1'b0, a, 8'h00, 4'hF);
    `CHK(nm, {24'h0, e}, x)
  endtask : rdc
  function automatic logic sig(input int s);
    return s == 0 ? iirq : s == 1 ? wirq : s == 2 ? cpu_rst : s == 3 ? stable : rc_en;
  endfunction : sig
  // bounded wait for an output level, then compare it
  task automatic wt(input int s, input logic val, input int lim, input string nm);
    int k;
    k = 0;
    while (sig(s) !== val && k < lim)
    begin
      @(posedge i_clk);
      k++;
    end
    `CHK(nm, val, sig(s))
  endtask : wt
  task automatic report_and_stop;
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (60000) @(posedge i_clk);
    failures++;
    report_and_stop();
  end
  initial
  begin
    i_arst_n = 1'b0; avs = '0; stop = 1'b0; ack_en = 1'b0; failures = 0; tests_run = 0; cyc = 0;
    repeat (20) @(posedge i_clk);
    i_arst_n <= 1'b1;
    rdc(A_IC, 8'h01, "ic_reset");
    rdc(A_IN, 8'h00, "in_reset");
    rdc(A_WC, 8'h00, "wc_reset");
    rdc(A_WN, 8'h00, "wn_reset");
    rdc(10'h000, 8'h00, "unmapped");
    `CHK("stable_rst", 1'b0, stable)
    // every clock select: exactly four ticks in four divider periods
    for (int c = 0; c < 4; c++)
    begin
      wr(A_IC, {1'b0, 2'(c), 5'h01});
      acc(1'b0, A_IN, 8'h00, 4'hF); v1 = x[7:0];
      repeat (dv[c] * 4 - 3) @(posedge i_clk);
      acc(1'b0, A_IN, 8'h00, 4'hF); v2 = x[7:0];
      `CHK("ic_rate", 8'h04, 8'(v2 - v1))
    end
    `CHK("stable_up", 1'b1, stable)
    // every overflow select, timed from a counter clear at divide-by-16
    for (int k = 0; k < 8; k++)
    begin
      wr(A_IC, 8'h68 | 8'(k));
      repeat (3) @(posedge i_clk);
      `CHK("iflag_clr", 1'b0, iirq)
      n = 3;
      while (iirq !== 1'b1 && n < 5000)
      begin
        @(posedge i_clk);
        n++;
      end
      `CHK("ovf_period", 1'b1, n >= (32 << k) - 2 && n <= (32 << k) + 3)
    end
    wr(A_IC, 8'hE7);
    rdc(A_IC, 8'hE7, "flag_w1");
    wr(A_IC, 8'h68);
    rdc(A_IC, 8'h60, "clr_self");
    rdc(A_IN, 8'h00, "clr_count");
    // watchdog on the 32-clock overflow with period 3
    ack_en <= 1'b1;
    wr(A_WN, 8'h03);
    wr(A_WC, 8'hA0);
    wt(1, 1'b1, 300, "wdt_irq");
    t1 = cyc;
    wt(1, 1'b0, 10, "wdt_ack");
    wt(1, 1'b1, 300, "wdt_irq2");
    `CHK("wdt_interval", 128, cyc - t1)
    wt(1, 1'b0, 10, "wdt_ack2");
    rdc(A_WC, 8'h80, "wcl_self");
    acc(1'b0, A_WN, 8'h00, 4'hF);
    `CHK("wdt_le_per", 1'b1, x[7:0] <= 8'h03)
    wr(A_WC, 8'hC0);
    wt(2, 1'b1, 300, "cpu_reset");
    wr(A_WC, 8'h00);
    acc(1'b0, A_WN, 8'h00, 4'hF); v1 = x[7:0];
    repeat (200) @(posedge i_clk);
    acc(1'b0, A_WN, 8'h00, 4'hF);
    `CHK("wdt_frozen", v1, x[7:0])
    acc(1'b1, A_WC, 8'h80, 4'hE);
    rdc(A_WC, 8'h00, "be_ignored");
    // rc clock while the interval timer is far too slow to matter
    wr(A_IC, 8'h07);
    wr(A_WC, 8'h82);
    wt(4, 1'b1, 5, "rc_enable");
    wt(1, 1'b1, 300, "rc_irq");
    t1 = cyc;
    wt(1, 1'b0, 10, "rc_ack");
    wt(1, 1'b1, 300, "rc_irq2");
    `CHK("rc_interval", 160, cyc - t1)
    wr(A_WC, 8'h00);
    // stop exit restarts the stabilisation wait
    wr(A_IC, 8'h60);
    stop <= 1'b1;
    @(posedge i_clk);
    stop <= 1'b0;
    repeat (3) @(posedge i_clk);
    `CHK("stop_wait", 1'b0, stable)
    wt(3, 1'b1, 80, "restable");
    report_and_stop();
  end
endmodule : itw_timer_test
